/* hw/gid_pkg.sv */
// package: register map, field layout, reset values and carriers for the gpio control block
package gid_pkg;

  // ----------------------------------------------------------------
  // pin grouping
  // ----------------------------------------------------------------
  localparam int unsigned GID_NUM_PINS = 11;
  localparam int unsigned GID_LOW_PINS = 6;
  localparam int unsigned GID_HIGH_PINS = 5;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GID_OFF_IRQ_EN_LOW = 8'h1f;
  localparam logic [7:0] GID_OFF_IRQ_EN_HIGH = 8'h20;
  localparam logic [7:0] GID_OFF_BYPASS_LOW = 8'h21;
  localparam logic [7:0] GID_OFF_BYPASS_HIGH = 8'h22;
  localparam logic [7:0] GID_OFF_LEVEL_LOW = 8'h23;
  localparam logic [7:0] GID_OFF_LEVEL_HIGH = 8'h24;
  localparam logic [7:0] GID_OFF_TYPE_LOW = 8'h25;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] GID_RST_LOW = 6'h00;
  localparam logic [4:0] GID_RST_HIGH = 5'h00;

  // ----------------------------------------------------------------
  // debounce timing: filter time in ns, cycle count derived from 25 ns clock
  // ----------------------------------------------------------------
  localparam int unsigned GID_CLK_PERIOD_NS = 25;
  localparam int unsigned GID_DEB_TIME_NS = 100;
  localparam int unsigned GID_DEB_CYCLES_INT =
    (GID_DEB_TIME_NS + GID_CLK_PERIOD_NS - 1) / GID_CLK_PERIOD_NS;
  localparam logic [3:0] GID_DEB_CYCLES = 4'(GID_DEB_CYCLES_INT);

  // ----------------------------------------------------------------
  // register access carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gid_reg_req_t;

endpackage

/* hw/gid_gpio_ctrl.sv */
// module: per-pin interrupt enable, input filter, output level and driver type control
//
// Overview of operation
// - An enabled pin whose flag is set and whose condition holds raises the summary input flag.
// - A pin whose interrupt enable is clear never contributes to the summary input flag.
// - The low enable register at 0x1f holds pins 1 to 6 in bits 0 to 5, bits 7:6 reserved.
// - The high enable register at 0x20 holds pins 7 to 11 in bits 0 to 4, bits 7:5 reserved.
// - Register 0x21 bits 0 to 5 bypass the input filter of pins 1 to 6 when set.
// - Register 0x22 bits 0 to 4 bypass the input filter of pins 7 to 11 when set.
// - Registers 0x23 and 0x24 set the driven level of pins 1 to 6 and 7 to 11.
// - Register 0x25 bits 0 to 5 choose push-pull at 0 or open drain at 1 for pins 1 to 6.
// - A polarity bit of 0 sets the pin flag while the pin is low, and 1 while it is high.
// - Pins recording events into the queue never produce per-pin summary interrupts.
// - Level and driver type reach a pin only while its output enable is set.
`timescale 1ns/1ps
module gid_gpio_ctrl
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // register port
  input wire gid_pkg::gid_reg_req_t i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // configuration held by neighbouring logic
  input wire logic [10:0] i_irq_polarity,
  input wire logic [10:0] i_event_mode,
  input wire logic [10:0] i_out_enable,
  input wire logic [4:0] i_driver_type_high,
  // flag clearing
  input wire logic [10:0] i_pin_flag_clr,
  input wire logic i_summary_clr,
  // pins
  input wire logic [10:0] i_pin_in,
  output logic [10:0] o_pin_out,
  output logic [10:0] o_pin_oe,
  // status
  output logic [10:0] o_pin_level,
  output logic [10:0] o_pin_irq_flag,
  output logic o_input_irq_summary_flag
);
  import gid_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] join_pins(input logic [5:0] lo, input logic [4:0] hi);
    join_pins = {hi, lo};
  endfunction

  function automatic logic hit(input gid_reg_req_t req, input logic [7:0] off);
    hit = req.wr && (req.addr == off);
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [5:0] irq_en_low_ff;
  logic [4:0] irq_en_high_ff;
  logic [5:0] bypass_low_ff;
  logic [4:0] bypass_high_ff;
  logic [5:0] level_low_ff;
  logic [4:0] level_high_ff;
  logic [5:0] type_low_ff;

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  wire logic wr_irq_en_low = hit(i_reg_req, GID_OFF_IRQ_EN_LOW);
  wire logic wr_irq_en_high = hit(i_reg_req, GID_OFF_IRQ_EN_HIGH);
  wire logic wr_bypass_low = hit(i_reg_req, GID_OFF_BYPASS_LOW);
  wire logic wr_bypass_high = hit(i_reg_req, GID_OFF_BYPASS_HIGH);
  wire logic wr_level_low = hit(i_reg_req, GID_OFF_LEVEL_LOW);
  wire logic wr_level_high = hit(i_reg_req, GID_OFF_LEVEL_HIGH);
  wire logic wr_type_low = hit(i_reg_req, GID_OFF_TYPE_LOW);

  // upper bits of each write are dropped
  wire logic [5:0] nxt_irq_en_low =
    wr_irq_en_low ? i_reg_req.wdata[5:0] : irq_en_low_ff;
  wire logic [4:0] nxt_irq_en_high =
    wr_irq_en_high ? i_reg_req.wdata[4:0] : irq_en_high_ff;
  wire logic [5:0] nxt_bypass_low =
    wr_bypass_low ? i_reg_req.wdata[5:0] : bypass_low_ff;
  wire logic [4:0] nxt_bypass_high =
    wr_bypass_high ? i_reg_req.wdata[4:0] : bypass_high_ff;
  wire logic [5:0] nxt_level_low =
    wr_level_low ? i_reg_req.wdata[5:0] : level_low_ff;
  wire logic [4:0] nxt_level_high =
    wr_level_high ? i_reg_req.wdata[4:0] : level_high_ff;
  wire logic [5:0] nxt_type_low =
    wr_type_low ? i_reg_req.wdata[5:0] : type_low_ff;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_en_low_ff <= GID_RST_LOW;
    else
      irq_en_low_ff <= nxt_irq_en_low;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_en_high_ff <= GID_RST_HIGH;
    else
      irq_en_high_ff <= nxt_irq_en_high;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      bypass_low_ff <= GID_RST_LOW;
    else
      bypass_low_ff <= nxt_bypass_low;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      bypass_high_ff <= GID_RST_HIGH;
    else
      bypass_high_ff <= nxt_bypass_high;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      level_low_ff <= GID_RST_LOW;
    else
      level_low_ff <= nxt_level_low;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      level_high_ff <= GID_RST_HIGH;
    else
      level_high_ff <= nxt_level_high;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      type_low_ff <= GID_RST_LOW;
    else
      type_low_ff <= nxt_type_low;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (i_reg_req.addr)
      GID_OFF_IRQ_EN_LOW: rd_mux = {2'h0, irq_en_low_ff};
      GID_OFF_IRQ_EN_HIGH: rd_mux = {3'h0, irq_en_high_ff};
      GID_OFF_BYPASS_LOW: rd_mux = {2'h0, bypass_low_ff};
      GID_OFF_BYPASS_HIGH: rd_mux = {3'h0, bypass_high_ff};
      GID_OFF_LEVEL_LOW: rd_mux = {2'h0, level_low_ff};
      GID_OFF_LEVEL_HIGH: rd_mux = {3'h0, level_high_ff};
      GID_OFF_TYPE_LOW: rd_mux = {2'h0, type_low_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  wire logic [7:0] nxt_reg_rdata = i_reg_req.rd ? rd_mux : 8'h00;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      reg_rdata_ff <= 8'h00;
    else
      reg_rdata_ff <= nxt_reg_rdata;
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      reg_rvalid_ff <= 1'b0;
    else
      reg_rvalid_ff <= i_reg_req.rd;
  end

  assign o_reg_rdata = reg_rdata_ff;
  assign o_reg_rvalid = reg_rvalid_ff;

  // ----------------------------------------------------------------
  // joined per-pin views
  // ----------------------------------------------------------------
  wire logic [10:0] irq_en = join_pins(irq_en_low_ff, irq_en_high_ff);
  wire logic [10:0] bypass = join_pins(bypass_low_ff, bypass_high_ff);
  wire logic [10:0] drive_level = join_pins(level_low_ff, level_high_ff);
  wire logic [10:0] driver_type = join_pins(type_low_ff, i_driver_type_high);

  // ----------------------------------------------------------------
  // per-pin input filter, flag and driver
  // ----------------------------------------------------------------
  logic [10:0] pin_val;
  logic [10:0] pin_cond;
  logic [10:0] contrib;
  logic [10:0] flag_ff;
  logic [10:0] pin_level_ff;
  logic [10:0] pin_out_ff;
  logic [10:0] pin_oe_ff;

  for (genvar i = 0; i < GID_NUM_PINS; i++)
  begin : g_pin
    logic stable_ff;
    logic [3:0] cnt_ff;
    wire logic differs = i_pin_in[i] != stable_ff;
    wire logic settled = differs && (cnt_ff == GID_DEB_CYCLES - 4'h1);
    wire logic [3:0] nxt_cnt = differs ? cnt_ff + 4'h1 : 4'h0;

    // a change is accepted only after it has held for the full filter time
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        cnt_ff <= 4'h0;
      else
        cnt_ff <= settled ? 4'h0 : nxt_cnt;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        stable_ff <= 1'b0;
      else if (settled)
        stable_ff <= i_pin_in[i];
    end

    assign pin_val[i] = bypass[i] ? i_pin_in[i] : stable_ff;
    assign pin_cond[i] = (pin_val[i] == i_irq_polarity[i]) && !i_event_mode[i];
    assign contrib[i] = flag_ff[i] && pin_cond[i] && irq_en[i];

    wire logic nxt_oe = i_out_enable[i] && (driver_type[i] ? !drive_level[i] : 1'b1);
    wire logic nxt_out = i_out_enable[i] && !driver_type[i] && drive_level[i];

    // ----------------------------------------------------------------
    // flag, level and driver registers
    // ----------------------------------------------------------------
    // set wins over a clear in the same cycle
    wire logic nxt_flag = pin_cond[i] || (flag_ff[i] && !i_pin_flag_clr[i]);

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        flag_ff[i] <= 1'b0;
      else
        flag_ff[i] <= nxt_flag;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        pin_level_ff[i] <= 1'b0;
      else
        pin_level_ff[i] <= pin_val[i];
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        pin_out_ff[i] <= 1'b0;
      else
        pin_out_ff[i] <= nxt_out;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
      if (!i_rstn)
        pin_oe_ff[i] <= 1'b0;
      else
        pin_oe_ff[i] <= nxt_oe;
    end
  end

  // ----------------------------------------------------------------
  // summary input flag
  // ----------------------------------------------------------------
  logic summary_ff;

  // a new contribution wins over a clear in the same cycle
  wire logic nxt_summary = (|contrib) || (summary_ff && !i_summary_clr);

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      summary_ff <= 1'b0;
    else
      summary_ff <= nxt_summary;
  end

  assign o_input_irq_summary_flag = summary_ff;
  assign o_pin_irq_flag = flag_ff;
  assign o_pin_level = pin_level_ff;
  assign o_pin_out = pin_out_ff;
  assign o_pin_oe = pin_oe_ff;

endmodule // gid_gpio_ctrl

/* test/gid_host.sv */
// host model: issues register requests on the parallel register port
`timescale 1ns/1ps
module gid_host
(
  // clock
  input wire logic i_clk_sys,
  // register port
  output gid_pkg::gid_reg_req_t o_req,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  import gid_pkg::*;
  initial o_req = '0;
  // released lines show the inverse of the last value, never a stale copy
  task automatic drop();
    o_req = '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) #2 o_req = '{1'b1, 1'b0, a, d};
    @(posedge i_clk_sys) #2 drop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(posedge i_clk_sys) #2 o_req = '{1'b0, 1'b1, a, ~o_req.wdata};
    @(posedge i_clk_sys) #2 r = {i_rvalid, i_rdata};
    drop();
  endtask
endmodule // gid_host

/* test/gid_gpio_ctrl_chk.sv */
// checker: port-level properties of the gpio control block
`timescale 1ns/1ps
module gid_gpio_ctrl_chk
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // observed ports
  input wire gid_pkg::gid_reg_req_t i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [10:0] i_event_mode,
  input wire logic [10:0] i_out_enable,
  input wire logic [4:0] i_driver_type_high,
  input wire logic [10:0] i_pin_flag_clr,
  input wire logic i_summary_clr,
  input wire logic [10:0] o_pin_out,
  input wire logic [10:0] o_pin_oe,
  input wire logic [10:0] o_pin_irq_flag,
  input wire logic o_input_irq_summary_flag
);
  import gid_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  wire bad_addr = (i_reg_req.addr < 8'h1f) || (i_reg_req.addr > 8'h25);
  sequence s_rd;
    i_reg_req.rd ##1 o_reg_rvalid;
  endsequence
  property p_rd; i_reg_req.rd |-> s_rd; endproperty
  property p_no_rd; !i_reg_req.rd |=> !o_reg_rvalid; endproperty
  property p_unmap; i_reg_req.rd && bad_addr |=> o_reg_rdata == 8'h00; endproperty
  property p_resv; i_reg_req.rd && !bad_addr |=> o_reg_rdata[7:6] == 2'h0; endproperty
  property p_sum_cause; $rose(o_input_irq_summary_flag) |-> $past(|o_pin_irq_flag); endproperty
  property p_sum_hold; $fell(o_input_irq_summary_flag) |-> $past(i_summary_clr); endproperty
  property p_flag_hold;
    ((($past(o_pin_irq_flag) & ~o_pin_irq_flag) & ~$past(i_pin_flag_clr)) == 11'h0);
  endproperty
  property p_event;
    (((o_pin_irq_flag & ~$past(o_pin_irq_flag)) & $past(i_event_mode)) == 11'h0);
  endproperty
  property p_oe_off; (((o_pin_oe | o_pin_out) & ~$past(i_out_enable)) == 11'h0); endproperty
  property p_od_high; ((o_pin_out[10:6] & $past(i_driver_type_high)) == 5'h0); endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  a_no_rd: assert property (p_no_rd) else $error("answer without read");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  a_sum_cause: assert property (p_sum_cause) else $error("summary without flag");
  a_sum_hold: assert property (p_sum_hold) else $error("summary dropped");
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  a_event: assert property (p_event) else $error("event pin flagged");
  a_oe_off: assert property (p_oe_off) else $error("disabled pin driven");
  a_od_high: assert property (p_od_high) else $error("open drain drives high");
endmodule // gid_gpio_ctrl_chk

/* test/testbench.sv */
// testbench: register map, pin drive, interrupt and input filter scenarios
`timescale 1ns/1ps
module testbench;
  import gid_pkg::*;
  logic i_clk_sys, i_rstn, rvalid, sclr, sum;
  gid_reg_req_t req;
  logic [7:0] rdata;
  logic [10:0] pol, evm, oen, fclr, pin, pout, poe, plev, pflag;
  logic [4:0] dth;
  int n_errors = 0;
  int check_count = 0;
  gid_gpio_ctrl DUT(.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_irq_polarity(pol), .i_event_mode(evm),
    .i_out_enable(oen), .i_driver_type_high(dth), .i_pin_flag_clr(fclr),
    .i_summary_clr(sclr), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
    .o_pin_level(plev), .o_pin_irq_flag(pflag), .o_input_irq_summary_flag(sum));
  gid_host host(.i_clk_sys(i_clk_sys), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
  task automatic check(input logic [10:0] g, input logic [10:0] e);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task automatic t_regs();
    logic [8:0] r;
    logic [7:0] a;
    for (int i = 0; i < 8; i++)
    begin
      a = 8'h1f + 8'(i);
      host.rd(a, r);
      check({2'h0, r}, {3'h1, 8'h00});
      host.wr(a, 8'hff);
      host.rd(a, r);
      check({2'h0, r}, {3'h1, (i == 7) ? 8'h00 : i[0] ? 8'h1f : 8'h3f});
    end
  endtask
  task automatic t_drive();
    host.wr(8'h23, 8'h05);
    host.wr(8'h25, 8'h04);
    dth = 5'h01;
    oen = 11'h7ff;
    step(2);
    check(pout, 11'h781);
    check(poe, 11'h7bb);
    oen = 11'h000;
    step(2);
    check(pout | poe, 11'h000);
  endtask
  task automatic t_irq();
    host.wr(8'h1f, 8'h00);
    evm = 11'h002;
    pin = 11'h003;
    step(3);
    check(pflag, 11'h001);
    check(sum, 1'b0);
    host.wr(8'h1f, 8'h01);
    step(2);
    check(sum, 1'b1);
    pin = 11'h000;
    step(2);
    fclr = 11'h7ff;
    sclr = 1'b1;
    step(1);
    fclr = 11'h000;
    sclr = 1'b0;
    step(1);
    check({pflag[0], sum}, 2'h0);
    pol = 11'h7fe;
    step(4);
    check({pflag[0], sum}, 2'h3);
  endtask
  task automatic t_filter();
    host.wr(8'h22, 8'h00);
    pin = 11'h040;
    step(2);
    check(plev[6], 1'b0);
    pin = 11'h000;
    step(3);
    check(plev[6], 1'b0);
    pin = 11'h040;
    step(6);
    check(plev[6], 1'b1);
    pin = 11'h041;
    step(1);
    check(plev[0], 1'b1);
  endtask
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    {i_rstn, sclr, evm, oen, dth, fclr, pin} = '0;
    pol = 11'h7ff;
    repeat (6) @(posedge i_clk_sys);
    #2 i_rstn = 1'b1;
    t_regs();
    t_drive();
    t_irq();
    t_filter();
    give_verdict();
  end
  initial
  begin
    #100us;
    n_errors++;
    give_verdict();
  end
endmodule // testbench
bind gid_gpio_ctrl gid_gpio_ctrl_chk u_chk(.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
  .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .i_event_mode(i_event_mode), .i_out_enable(i_out_enable),
  .i_driver_type_high(i_driver_type_high), .i_pin_flag_clr(i_pin_flag_clr),
  .i_summary_clr(i_summary_clr), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_pin_irq_flag(o_pin_irq_flag), .o_input_irq_summary_flag(o_input_irq_summary_flag));
